// [verilog/mo_order_ctrl.sv]
// Memory-ordering sequencer for legacy and native memory operations
`include "mo_defines.svh"
module mo_order_ctrl import mo_pkg::*; #(
  parameter int SB_DEPTH = `MO_SB_DEPTH,
  parameter int LQ_DEPTH = `MO_LQ_DEPTH,
  parameter int AW = `MO_ADDR_W,
  parameter int DW = `MO_DATA_W,
  parameter int LINE_LSB = `MO_LINE_LSB
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_op_valid,
  input wire mo_op_t i_op_kind,
  input wire logic i_op_legacy,
  input wire mo_mtype_t i_op_mtype,
  input wire logic [AW-1:0] i_op_addr,
  input wire logic [DW-1:0] i_op_wdata,
  input wire logic i_ld_retire,
  input wire logic i_snoop_valid,
  input wire logic [AW-1:0] i_snoop_addr,
  input wire logic i_mem_ready,
  input wire logic i_port_ack,
  input wire logic i_fetch_req,
  input wire logic i_fetch_spec,
  input wire logic [AW-1:0] i_fetch_addr,
  input wire logic i_walk_req,
  output logic o_op_accept,
  output logic o_mem_valid,
  output logic o_mem_write,
  output logic o_mem_lock,
  output logic o_mem_port,
  output logic o_mem_ordered,
  output mo_mtype_t o_mem_mtype,
  output logic [AW-1:0] o_mem_addr,
  output logic [DW-1:0] o_mem_wdata,
  output logic o_wc_flush,
  output logic o_smc_flush,
  output logic o_replay,
  output logic o_fetch_grant,
  output logic o_fetch_discard,
  output logic o_walk_grant,
  output logic o_sb_empty,
  output logic o_legacy_hold
);
  localparam int CW = $clog2(SB_DEPTH + 1);
  localparam logic [CW-1:0] SB_FULL = CW'(SB_DEPTH);

  // Parameter sanity
  if (SB_DEPTH < 1 || LQ_DEPTH < 1 || LINE_LSB >= AW) begin : g_chk
    $error("mo_order_ctrl: unsupported parameters");
  end

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    mo_mtype_t mtype;
    logic ord;
    logic leg;
  } mo_sb_ent_t;

  typedef struct packed {
    mo_fsm_t fsm;
    mo_sb_ent_t [SB_DEPTH-1:0] sb;
    logic [CW-1:0] cnt;
    mo_op_t cur_kind;
    logic cur_leg;
    mo_mtype_t cur_mtype;
    logic [AW-1:0] cur_addr;
    logic [DW-1:0] cur_data;
    logic last_leg;
    logic op_accept;
    logic mem_valid;
    logic mem_write;
    logic mem_lock;
    logic mem_port;
    logic mem_ordered;
    mo_mtype_t mem_mtype;
    logic [AW-1:0] mem_addr;
    logic [DW-1:0] mem_wdata;
    logic wc_flush;
    logic smc_flush;
    logic replay;
    logic fetch_grant;
    logic fetch_discard;
    logic walk_grant;
    logic sb_empty;
    logic legacy_hold;
  } mo_st_t;

  mo_st_t st_r;
  mo_st_t st_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic lq_alloc;

  mo_trk_if #(.AW(AW)) trk ();

  // Same cache line test
  function automatic logic same_line(input logic [AW-1:0] a,
                                     input logic [AW-1:0] b);
    same_line = a[AW-1:LINE_LSB] == b[AW-1:LINE_LSB];
  endfunction : same_line

  // Any buffered store to the line, optionally legacy stores only
  function automatic logic sb_hit(input mo_st_t s, input logic [AW-1:0] a,
                                  input logic leg_only);
    sb_hit = 1'b0;
    for (int i = 0; i < SB_DEPTH; i++) begin
      if (CW'(i) < s.cnt && same_line(s.sb[i].addr, a) &&
          (s.sb[i].leg || !leg_only)) begin
        sb_hit = 1'b1;
      end
    end
  endfunction : sb_hit

  // Reset release through two flip-flops
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_r <= `MO_RST_SYNC_INIT;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Load tracker for speculative acquire loads
  mo_load_tracker #(.DEPTH(LQ_DEPTH), .AW(AW), .LINE_LSB(LINE_LSB)) u_trk (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .t(trk.trk)
  );
  assign trk.alloc = lq_alloc;
  assign trk.alloc_addr = st_r.cur_addr;
  assign trk.retire = i_ld_retire;
  assign trk.snoop_valid = i_snoop_valid;
  assign trk.snoop_addr = i_snoop_addr;

  // Sequencer, store buffer and bus request next state
  always_comb begin
    logic take;
    logic ser_busy;
    logic guard;
    take = i_op_valid && !st_r.op_accept;
    ser_busy = st_r.fsm != S_IDLE && st_r.cur_kind == OP_SERIAL;
    // Native access after legacy acquires waits for them to retire
    guard = !i_op_legacy && st_r.last_leg && trk.busy;
    st_nxt = st_r;
    lq_alloc = 1'b0;
    st_nxt.op_accept = 1'b0;
    st_nxt.wc_flush = 1'b0;
    st_nxt.smc_flush = 1'b0;
    if (st_r.mem_valid && i_mem_ready) begin
      st_nxt.mem_valid = 1'b0;
    end
    unique case (st_r.fsm)
      S_IDLE: begin
        if (take && !guard && i_op_kind == OP_STORE &&
            st_r.cnt != SB_FULL) begin
          // Stores queue in order, so none passes an earlier access
          st_nxt.sb[st_r.cnt].addr = i_op_addr;
          st_nxt.sb[st_r.cnt].data = i_op_wdata;
          st_nxt.sb[st_r.cnt].mtype = i_op_mtype;
          st_nxt.sb[st_r.cnt].ord = i_op_mtype != MT_WC;
          st_nxt.sb[st_r.cnt].leg = i_op_legacy;
          st_nxt.cnt = st_r.cnt + CW'(1);
          st_nxt.op_accept = 1'b1;
          st_nxt.last_leg = i_op_legacy;
          st_nxt.wc_flush = i_op_legacy && i_op_mtype == MT_UC;
          // Legacy store into the fetch line discards stale fetches
          st_nxt.smc_flush = i_op_legacy &&
            same_line(i_op_addr, i_fetch_addr);
        end else if (take && !guard && i_op_kind == OP_LOAD &&
                     !st_r.mem_valid &&
                     !sb_hit(st_r, i_op_addr, 1'b0) &&
                     !(i_op_legacy && trk.full)) begin
          // Loads pass buffered stores to other lines; one at a time
          st_nxt.mem_valid = 1'b1;
          st_nxt.mem_write = 1'b0;
          st_nxt.mem_lock = 1'b0;
          st_nxt.mem_port = 1'b0;
          st_nxt.mem_ordered = i_op_legacy;
          st_nxt.mem_mtype = i_op_mtype;
          st_nxt.mem_addr = i_op_addr;
          st_nxt.cur_kind = i_op_kind;
          st_nxt.cur_leg = i_op_legacy;
          st_nxt.cur_mtype = i_op_mtype;
          st_nxt.cur_addr = i_op_addr;
          st_nxt.last_leg = i_op_legacy;
          st_nxt.fsm = S_MEM;
        end else if (take && !guard && i_op_kind != OP_STORE &&
                     i_op_kind != OP_LOAD) begin
          st_nxt.cur_kind = i_op_kind;
          st_nxt.cur_leg = i_op_legacy;
          st_nxt.cur_mtype = i_op_mtype;
          st_nxt.cur_addr = i_op_addr;
          st_nxt.cur_data = i_op_wdata;
          st_nxt.last_leg = i_op_legacy;
          st_nxt.fsm = S_DRAIN;
        end
      end
      S_DRAIN: begin
        // Fences wait for an empty buffer and an idle bus
        if (st_r.cnt == '0 && !st_r.mem_valid) begin
          st_nxt.mem_addr = st_r.cur_addr;
          st_nxt.mem_wdata = st_r.cur_data;
          st_nxt.mem_mtype = st_r.cur_mtype;
          st_nxt.mem_ordered = 1'b1;
          st_nxt.mem_write = st_r.cur_kind != OP_PORT_IN;
          st_nxt.mem_lock = st_r.cur_kind == OP_LOCKED;
          st_nxt.mem_port = st_r.cur_kind == OP_PORT_IN ||
                            st_r.cur_kind == OP_PORT_OUT;
          if (st_r.cur_kind == OP_BARRIER || st_r.cur_kind == OP_SERIAL) begin
            st_nxt.op_accept = 1'b1;
            st_nxt.fsm = S_IDLE;
          end else begin
            st_nxt.mem_valid = 1'b1;
            st_nxt.fsm = S_MEM;
          end
        end
      end
      S_MEM: begin
        if (st_r.mem_valid && i_mem_ready) begin
          // Only legacy port instructions wait for acceptance
          if (st_r.mem_port && st_r.cur_leg) begin
            st_nxt.fsm = S_ACK;
          end else begin
            st_nxt.op_accept = 1'b1;
            st_nxt.fsm = S_IDLE;
            st_nxt.wc_flush = st_r.cur_leg && st_r.cur_kind == OP_LOAD &&
                              st_r.cur_mtype == MT_UC;
            lq_alloc = st_r.cur_leg && st_r.cur_kind == OP_LOAD &&
                       st_r.cur_mtype != MT_UC;
          end
        end
      end
      S_ACK: begin
        if (i_port_ack) begin
          st_nxt.op_accept = 1'b1;
          st_nxt.fsm = S_IDLE;
        end
      end
    endcase
    // Drain the buffer head in order whenever the bus is free
    if (st_r.fsm != S_MEM && st_r.fsm != S_ACK && !st_nxt.mem_valid &&
        !st_r.mem_valid && st_r.cnt != '0) begin
      st_nxt.mem_valid = 1'b1;
      st_nxt.mem_write = 1'b1;
      st_nxt.mem_lock = 1'b0;
      st_nxt.mem_port = 1'b0;
      st_nxt.mem_ordered = st_r.sb[0].ord;
      st_nxt.mem_mtype = st_r.sb[0].mtype;
      st_nxt.mem_addr = st_r.sb[0].addr;
      st_nxt.mem_wdata = st_r.sb[0].data;
      for (int i = 0; i < SB_DEPTH - 1; i++) begin
        st_nxt.sb[i] = st_nxt.sb[i+1];
      end
      st_nxt.cnt = st_nxt.cnt - CW'(1);
    end
    // Fetch ignores loads, fences and native stores but not legacy stores to its line or serialization
    st_nxt.fetch_grant = i_fetch_req &&
      !(ser_busy && !i_fetch_spec) &&
      !sb_hit(st_r, i_fetch_addr, 1'b1);
    st_nxt.fetch_discard = i_fetch_req && ser_busy && i_fetch_spec;
    st_nxt.walk_grant = i_walk_req;
    st_nxt.replay = trk.replay;
    st_nxt.sb_empty = st_nxt.cnt == '0;
    st_nxt.legacy_hold = st_nxt.fsm == S_ACK ||
      (st_nxt.fsm == S_MEM && st_nxt.mem_port && st_nxt.cur_leg);
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.sb_empty <= 1'b1;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign o_op_accept = st_r.op_accept;
  assign o_mem_valid = st_r.mem_valid;
  assign o_mem_write = st_r.mem_write;
  assign o_mem_lock = st_r.mem_lock;
  assign o_mem_port = st_r.mem_port;
  assign o_mem_ordered = st_r.mem_ordered;
  assign o_mem_mtype = st_r.mem_mtype;
  assign o_mem_addr = st_r.mem_addr;
  assign o_mem_wdata = st_r.mem_wdata;
  assign o_wc_flush = st_r.wc_flush;
  assign o_smc_flush = st_r.smc_flush;
  assign o_replay = st_r.replay;
  assign o_fetch_grant = st_r.fetch_grant;
  assign o_fetch_discard = st_r.fetch_discard;
  assign o_walk_grant = st_r.walk_grant;
  assign o_sb_empty = st_r.sb_empty;
  assign o_legacy_hold = st_r.legacy_hold;

  // Checks on ordering behaviour
  property p_lock_drained;
    @(posedge i_clk_sys) disable iff (!rst_n)
    o_mem_valid && o_mem_lock |-> st_r.cnt == '0 && o_sb_empty;
  endproperty
  a_lock_drained: assert property (p_lock_drained)
    else $error("locked access issued with stores buffered");

  property p_port_drained;
    @(posedge i_clk_sys) disable iff (!rst_n)
    $rose(o_mem_valid && o_mem_port) |-> $past(st_r.cnt) == '0;
  endproperty
  a_port_drained: assert property (p_port_drained)
    else $error("port access issued with stores buffered");

  property p_port_hold;
    @(posedge i_clk_sys) disable iff (!rst_n)
    st_r.fsm == S_ACK && !i_port_ack && i_ce |=>
      !o_op_accept && o_legacy_hold && st_r.fsm == S_ACK;
  endproperty
  a_port_hold: assert property (p_port_hold)
    else $error("port wait left without acceptance");

  property p_native_nowait;
    @(posedge i_clk_sys) disable iff (!rst_n)
    st_r.fsm == S_ACK |-> st_r.cur_leg && st_r.mem_port;
  endproperty
  a_native_nowait: assert property (p_native_nowait)
    else $error("native access held for port acceptance");

  property p_wc_unordered;
    @(posedge i_clk_sys) disable iff (!rst_n)
    o_mem_valid && o_mem_write && !o_mem_lock && !o_mem_port |->
      o_mem_ordered == (o_mem_mtype != MT_WC);
  endproperty
  a_wc_unordered: assert property (p_wc_unordered)
    else $error("store ordering does not match memory type");

  property p_wc_flush_uc;
    @(posedge i_clk_sys) disable iff (!rst_n)
    i_ce && st_r.fsm == S_IDLE && i_op_valid && !st_r.op_accept &&
    i_op_kind == OP_STORE && i_op_legacy && i_op_mtype == MT_WB
      |=> !o_wc_flush;
  endproperty
  a_wc_flush_uc: assert property (p_wc_flush_uc)
    else $error("cacheable store flushed write-coalescing buffers");

  property p_fetch_serial;
    @(posedge i_clk_sys) disable iff (!rst_n)
    i_ce && st_r.fsm != S_IDLE && st_r.cur_kind == OP_SERIAL &&
    i_fetch_req && !i_fetch_spec |=> !o_fetch_grant;
  endproperty
  a_fetch_serial: assert property (p_fetch_serial)
    else $error("fetch passed a serializing operation");

  property p_fetch_store;
    @(posedge i_clk_sys) disable iff (!rst_n)
    i_ce && i_fetch_req && sb_hit(st_r, i_fetch_addr, 1'b1)
      |=> !o_fetch_grant;
  endproperty
  a_fetch_store: assert property (p_fetch_store)
    else $error("fetch passed a buffered legacy store");

  property p_native_after_acq;
    @(posedge i_clk_sys) disable iff (!rst_n)
    i_ce && st_r.fsm == S_IDLE && i_op_valid && !i_op_legacy &&
    st_r.last_leg && trk.busy |=> st_r.fsm == S_IDLE && !o_op_accept;
  endproperty
  a_native_after_acq: assert property (p_native_after_acq)
    else $error("native access passed a legacy acquire load");

  property p_walk;
    @(posedge i_clk_sys) disable iff (!rst_n)
    i_ce && i_walk_req |=> o_walk_grant;
  endproperty
  a_walk: assert property (p_walk)
    else $error("page walk not granted");

  property p_replay;
    @(posedge i_clk_sys) disable iff (!rst_n)
    i_ce && trk.replay |=> o_replay;
  endproperty
  a_replay: assert property (p_replay)
    else $error("snoop hit did not replay loads");

  // Main scenarios
  c_port_done: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
    st_r.fsm == S_ACK ##1 o_op_accept);
  c_replay: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
    o_replay);
  c_serial: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
    o_fetch_discard ##[1:20] o_op_accept);
endmodule : mo_order_ctrl

// [verilog/mo_defines.svh]
// Constants for the legacy memory-ordering controller
`ifndef MO_DEFINES_SVH
`define MO_DEFINES_SVH
// Store buffer entries (depth is implementation dependent)
`define MO_SB_DEPTH 4
// Speculative acquire load tracker entries
`define MO_LQ_DEPTH 4
// Address and data widths
`define MO_ADDR_W 32
`define MO_DATA_W 32
// Lowest address bit above the cache line offset
`define MO_LINE_LSB 6
// Reset value of the two-stage reset synchroniser
`define MO_RST_SYNC_INIT 2'h0
`endif

// [verilog/mo_pkg.sv]
// Types shared by the memory-ordering controller and its load tracker
package mo_pkg;
  // Operation kinds offered by the issue stage
  typedef enum logic [2:0] {
    OP_LOAD, OP_STORE, OP_LOCKED, OP_PORT_IN, OP_PORT_OUT,
    OP_BARRIER, OP_SERIAL
  } mo_op_t;
  // Memory types: uncacheable, write-coalescing, cacheable
  typedef enum logic [1:0] {MT_UC, MT_WC, MT_WB} mo_mtype_t;
  // Sequencer states
  typedef enum logic [1:0] {S_IDLE, S_DRAIN, S_MEM, S_ACK} mo_fsm_t;
endpackage : mo_pkg

// [verilog/mo_trk_if.sv]
// Link between the ordering sequencer and the acquire load tracker
interface mo_trk_if #(parameter int AW = 32) ();
  logic alloc;
  logic [AW-1:0] alloc_addr;
  logic retire;
  logic snoop_valid;
  logic [AW-1:0] snoop_addr;
  logic busy;
  logic full;
  logic replay;
  modport ctrl (output alloc, alloc_addr, retire, snoop_valid, snoop_addr,
    input busy, full, replay);
  modport trk (input alloc, alloc_addr, retire, snoop_valid, snoop_addr,
    output busy, full, replay);
endinterface : mo_trk_if

// [verilog/mo_load_tracker.sv]
// Tracker of speculatively completed acquire loads awaiting retirement
`include "mo_defines.svh"
module mo_load_tracker import mo_pkg::*; #(
  parameter int DEPTH = `MO_LQ_DEPTH,
  parameter int AW = `MO_ADDR_W,
  parameter int LINE_LSB = `MO_LINE_LSB
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  mo_trk_if.trk t
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  // Parameter sanity
  if (DEPTH < 1 || LINE_LSB >= AW) begin : g_chk
    $error("mo_load_tracker: unsupported parameters");
  end

  typedef struct packed {
    logic [DEPTH-1:0][AW-1:0] addr;
    logic [CW-1:0] cnt;
    logic busy;
    logic full;
    logic replay;
  } mo_trk_st_t;

  mo_trk_st_t st_r;
  mo_trk_st_t st_nxt;

  // Oldest-first queue; a snoop hit on any held line forces a replay
  always_comb begin
    st_nxt = st_r;
    st_nxt.replay = 1'b0;
    if (t.retire && st_r.cnt != '0) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        st_nxt.addr[i] = st_r.addr[i+1];
      end
      st_nxt.cnt = st_r.cnt - CW'(1);
    end
    if (t.alloc && st_nxt.cnt != FULL_CNT) begin
      st_nxt.addr[st_nxt.cnt] = t.alloc_addr;
      st_nxt.cnt = st_nxt.cnt + CW'(1);
    end
    for (int i = 0; i < DEPTH; i++) begin
      if (t.snoop_valid && CW'(i) < st_r.cnt &&
          st_r.addr[i][AW-1:LINE_LSB] == t.snoop_addr[AW-1:LINE_LSB]) begin
        st_nxt.replay = 1'b1;
      end
    end
    // Replayed loads are reissued in order, so the queue empties
    if (st_nxt.replay) begin
      st_nxt.cnt = '0;
    end
    st_nxt.busy = st_nxt.cnt != '0;
    st_nxt.full = st_nxt.cnt == FULL_CNT;
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign t.busy = st_r.busy;
  assign t.full = st_r.full;
  assign t.replay = st_r.replay;
endmodule : mo_load_tracker

// [verification/mo_platform_model.sv]
// Behavioural platform memory and port system facing the ordering block
module mo_platform_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_mem_valid,
  input wire logic i_mem_port,
  input wire logic i_slow,
  input wire logic i_ack_en,
  output logic o_mem_ready,
  output logic o_port_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_r;
  int ack_r;
  // Takes requests promptly or after a wait, then accepts port transfers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_ready <= 1'b0;
      o_port_ack <= 1'b0;
      wait_r <= 0;
      ack_r <= 0;
    end else begin
      o_port_ack <= 1'b0;
      if (o_mem_ready && i_mem_valid) begin
        o_mem_ready <= 1'b0;
        wait_r <= i_slow ? 3 : 0;
        if (i_mem_port) ack_r <= i_slow ? 4 : 1;
      end else if (i_mem_valid && wait_r == 0) begin
        o_mem_ready <= 1'b1;
      end else if (wait_r > 0) begin
        wait_r <= wait_r - 1;
      end
      if (ack_r > 0) ack_r <= ack_r - 1;
      if (ack_r == 1 && i_ack_en) o_port_ack <= 1'b1;
    end
  end
endmodule : mo_platform_model

// [verification/tb_mo_order_ctrl.sv]
// Self-checking bench for the memory-ordering sequencer
module tb_mo_order_ctrl import mo_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 0, i_reset_n = 0, i_op_valid = 0, i_op_legacy = 0;
  logic i_ld_retire = 0, i_snoop_valid = 0, i_walk_req = 0, slow = 0;
  logic ack_en = 1, i_mem_ready, i_port_ack, run = 0;
  mo_op_t i_op_kind = OP_LOAD;
  mo_mtype_t i_op_mtype = MT_UC;
  logic [31:0] i_op_addr = 0, i_op_wdata = 0, i_snoop_addr = 0;
  logic [31:0] seed = 32'h0811, wseed = 32'h0811;
  logic o_op_accept, o_mem_valid, o_mem_write, o_mem_lock, o_mem_port;
  logic o_mem_ordered, o_wc_flush, o_smc_flush, o_replay, o_fetch_grant;
  logic o_fetch_discard, o_walk_grant, o_sb_empty, o_legacy_hold;
  logic seen_wc, seen_hold, seen_ack, seen_rep, last_ord, last_lock;
  logic port_sb, acc_sb, walk_q = 0, i_fetch_spec = 0;
  logic seen_smc, seen_deny, seen_disc;
  logic [31:0] o_mem_addr, o_mem_wdata, last_addr, last_data;
  mo_mtype_t o_mem_mtype, last_mt;
  int lat;
  int failures = 0, compares = 0;
  mo_op_t fences [5] = '{OP_LOCKED, OP_BARRIER, OP_SERIAL, OP_PORT_OUT,
    OP_PORT_IN};

  // Clock at 25 MHz
  always #20 i_clk_sys = ~i_clk_sys;

  mo_order_ctrl mo_order_ctrl_i (.i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n), .i_ce(1'b1), .i_op_valid(i_op_valid),
    .i_op_kind(i_op_kind), .i_op_legacy(i_op_legacy),
    .i_op_mtype(i_op_mtype), .i_op_addr(i_op_addr),
    .i_op_wdata(i_op_wdata), .i_ld_retire(i_ld_retire),
    .i_snoop_valid(i_snoop_valid), .i_snoop_addr(i_snoop_addr),
    .i_mem_ready(i_mem_ready), .i_port_ack(i_port_ack),
    .i_fetch_req(1'b1), .i_fetch_spec(i_fetch_spec),
    .i_fetch_addr(32'h0004_0000), .i_walk_req(i_walk_req),
    .o_op_accept(o_op_accept), .o_mem_valid(o_mem_valid),
    .o_mem_write(o_mem_write), .o_mem_lock(o_mem_lock),
    .o_mem_port(o_mem_port), .o_mem_ordered(o_mem_ordered),
    .o_mem_mtype(o_mem_mtype), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata),
    .o_wc_flush(o_wc_flush), .o_smc_flush(o_smc_flush),
    .o_replay(o_replay), .o_fetch_grant(o_fetch_grant),
    .o_fetch_discard(o_fetch_discard), .o_walk_grant(o_walk_grant),
    .o_sb_empty(o_sb_empty), .o_legacy_hold(o_legacy_hold));

  mo_platform_model mo_platform_model_i (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_reset_n), .i_mem_valid(o_mem_valid),
    .i_mem_port(o_mem_port), .i_slow(slow), .i_ack_en(ack_en),
    .o_mem_ready(i_mem_ready), .o_port_ack(i_port_ack));

  // Compares one value with its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Prints the verdict and ends the run
  task automatic close_out();
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // Write-coalescing flush is expected for uncacheable accesses only
  function automatic logic exp_wc(input mo_mtype_t mt);
    return mt == MT_UC;
  endfunction : exp_wc

  // Stores are ordered unless they target write-coalescing memory
  function automatic logic exp_ord(input mo_mtype_t mt);
    return mt != MT_WC;
  endfunction : exp_ord

  // Records events seen on the outputs and the memory bus
  always @(posedge i_clk_sys) begin
    if (o_wc_flush) seen_wc = 1;
    if (o_legacy_hold) seen_hold = 1;
    if (i_port_ack) seen_ack = 1;
    if (o_replay) seen_rep = 1;
    if (o_smc_flush) seen_smc = 1;
    if (!o_fetch_grant) seen_deny = 1;
    if (o_fetch_discard) seen_disc = 1;
    if (o_mem_valid && i_mem_ready) begin
      last_ord = o_mem_ordered;
      last_addr = o_mem_addr;
      last_data = o_mem_wdata;
      last_mt = o_mem_mtype;
      last_lock = o_mem_lock;
      if (o_mem_port) port_sb = o_sb_empty;
    end
  end

  // Random page-walk requests, granted one cycle later at all times
  always @(negedge i_clk_sys) begin
    if (run) begin
      check(o_walk_grant, walk_q);
      walk_q = $random(wseed);
      i_walk_req = walk_q;
      i_fetch_spec = ~i_fetch_spec; // Alternate speculative and non-speculative fetch
    end
  end

  // Presents one operation and holds it until it is accepted
  task automatic do_op(input mo_op_t k, input logic leg,
    input mo_mtype_t mt, input logic [31:0] a);
    int n;
    seen_wc = 0;
    seen_hold = 0;
    seen_ack = 0;
    seen_smc = 0;
    seen_deny = 0;
    seen_disc = 0;
    slow = $random(seed);
    i_op_valid = 1;
    i_op_kind = k;
    i_op_legacy = leg;
    i_op_mtype = mt;
    i_op_addr = a;
    i_op_wdata = $random(seed);
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (o_op_accept !== 1'b1 && n < 400);
    if (n >= 400) begin
      failures++;
      close_out();
    end
    acc_sb = o_sb_empty;
    lat = n;
  endtask : do_op

  // Releases the request and waits for the store buffer and bus to settle
  task automatic drain();
    int n;
    i_op_valid = 0;
    n = 0;
    while ((o_sb_empty !== 1'b1 || o_mem_valid !== 1'b0) && n < 400) begin
      @(negedge i_clk_sys);
      n++;
    end
    if (n >= 400) begin
      failures++;
      close_out();
    end
    repeat (3) @(negedge i_clk_sys);
  endtask : drain

  // Main sequence
  initial begin
    repeat (16) @(negedge i_clk_sys);
    check(o_sb_empty, 1);
    check(o_mem_valid, 0);
    i_reset_n = 1;
    repeat (4) @(negedge i_clk_sys);
    run = 1;
    for (int m = 0; m < 3; m++) begin
      do_op(OP_STORE, 1, mo_mtype_t'(m), $random(seed));
      drain();
      check(seen_wc, exp_wc(mo_mtype_t'(m)));
      check(last_ord, exp_ord(mo_mtype_t'(m)));
      check(last_mt, m);
      check(last_addr, i_op_addr);
      check(last_data, i_op_wdata);
    end
    foreach (fences[f]) begin
      repeat (1 + ($unsigned($random(seed)) % 4))
        do_op(OP_STORE, 1, MT_WB, $random(seed));
      do_op(fences[f], 1, MT_UC, $random(seed));
      check(acc_sb, 1);
      if (f == 0) check(last_lock, 1);
      if (f > 2) begin
        check(port_sb, 1);
        check(seen_hold & seen_ack, 1);
      end
      drain();
      check(seen_disc, f == 2);
      check(seen_deny, f == 2);
    end
    ack_en = 0;
    do_op(OP_PORT_OUT, 0, MT_UC, 32'h0000_1000);
    check(seen_hold, 0);
    drain();
    ack_en = 1;
    // Only a legacy store into the fetch line blocks and flushes fetch
    for (int l = 0; l < 2; l++) begin
      do_op(OP_STORE, l[0], MT_WB, 32'h0004_0010);
      drain();
      check(seen_smc, l);
      check(seen_deny, l);
    end
    for (int m = 0; m < 3; m += 2) begin
      do_op(OP_LOAD, 1, mo_mtype_t'(m), 32'h0000_2000);
      drain();
      check(seen_wc, exp_wc(mo_mtype_t'(m)));
    end
    // Native op waits until the tracked legacy acquire load retires
    fork
      begin
        repeat (6) @(negedge i_clk_sys);
        i_ld_retire = 1;
        @(negedge i_clk_sys);
        i_ld_retire = 0;
      end
      do_op(OP_STORE, 0, MT_WB, 32'h0000_5000);
    join
    check(lat > 6, 1);
    do_op(OP_LOAD, 1, MT_WB, 32'h0000_3040);
    i_op_valid = 0;
    seen_rep = 0;
    i_snoop_valid = 1;
    i_snoop_addr = 32'h0000_3048;
    @(negedge i_clk_sys);
    i_snoop_valid = 0;
    repeat (4) @(negedge i_clk_sys);
    check(seen_rep, 1);
    drain();
    check(o_fetch_grant, 1);
    close_out();
  end

  // Watchdog against a hang
  initial begin
    #(40 * 20000);
    failures++;
    close_out();
  end
endmodule : tb_mo_order_ctrl
